//--- rtl/cbp_top.v
// Purpose: cache bypass, coherence and prefetch control between core and backplane bus
// Assumes: core strobes and the bus slave handshake run on clk_in; addresses are physical,
//          already relocated, with the page descriptor of that relocation presented alongside
// Notes:   write-through cache, read allocate; one outstanding reference at a time
`timescale 1ns/1ps
`include "cbp_defines.vh"
module cbp_top #(
   parameter AW    = `CBP_AW,
   parameter DW    = `CBP_DW,
   parameter IDX_W = `CBP_IDX_W
) (
   input  wire          clk_in,            // 10 MHz clock
   input  wire          rst_n_in,          // async reset, low
   input  wire          dat_req_in,        // data reference, held to done
   input  wire          dat_we_in,         // 1 write, 0 read
   input  wire [AW-1:0] dat_addr_in,       // data address
   input  wire [DW-1:0] dat_wdata_in,      // write data
   input  wire [DW-1:0] dat_desc_in,       // page descriptor of data ref
   output reg           dat_done_out,      // data ref done, pulse
   output reg  [DW-1:0] dat_rdata_out,     // read data
   input  wire          ins_req_in,        // instruction wanted, held to done
   input  wire [AW-1:0] ins_addr_in,       // instruction address
   input  wire [DW-1:0] ins_desc_in,       // page descriptor of code page
   output reg           ins_done_out,      // instruction ready, pulse
   output reg  [DW-1:0] ins_data_out,      // instruction word
   output reg           ins_flow_out,      // predecode: alters flow
   input  wire          psw_wr_in,         // status word written
   input  wire          pc_wr_in,          // program counter written
   input  wire          mmu_wr_in,         // mapping register written
   input  wire          branch_taken_in,   // taken branch
   input  wire          ccr_wr_in,         // cache control written
   input  wire [DW-1:0] ccr_wdata_in,      // cache control data
   output reg  [DW-1:0] ccr_rdata_out,     // cache control readback
   output reg           cache_on_out,      // cache currently enabled
   output reg           bus_req_out,       // bus cycle request, level
   output reg           bus_we_out,        // bus write
   output reg  [AW-1:0] bus_addr_out,      // bus address
   output reg  [DW-1:0] bus_wdata_out,     // bus write data
   input  wire          bus_ack_in,        // bus cycle done, pulse
   input  wire [DW-1:0] bus_rdata_in,      // bus read data
   output reg           bus_map_ind_n_out  // map indicator, low active
);
   localparam TAG_W = AW - 1 - IDX_W;

   reg  [1:0]       st_ff;
   reg              op_kind_ff;
   reg  [AW-1:0]    op_addr_ff;
   reg              op_we_ff;
   reg  [DW-1:0]    op_wdata_ff;
   reg              op_io_ff;
   reg              op_byp_ff;
   reg              op_hit_ff;
   reg              op_cach_ff;
   reg              pf_want_ff;
   reg  [AW-1:0]    pf_addr_ff;
   reg              pf_drop_ff;
   reg  [DW-1:0]    ccr_ff;

   wire             m_valid;
   wire [TAG_W-1:0] m_tag;
   wire [DW-1:0]    m_data;
   wire             pb_valid;
   wire [AW-1:0]    pb_addr;
   wire [DW-1:0]    pb_data;
   wire             pb_flow;

   reg  [IDX_W-1:0] rd_idx;
   reg              mw_en;
   reg              mw_valid;
   reg  [DW-1:0]    mw_data;
   reg              pb_load;
   reg  [DW-1:0]    pb_ldata;
   reg              pb_take;

   wire             flush;
   wire             cache_on;
   wire             take_dat;
   wire             take_ins;
   wire             pb_hit;
   wire             tag_hit;
   wire             cacheable;

   // flow-altering writes and taken branches flush
   assign flush = psw_wr_in | pc_wr_in | mmu_wr_in | ccr_wr_in | branch_taken_in;

   // either disable bit turns the cache off
   assign cache_on = ~(ccr_ff[`CBP_CCR_OFF_LO] | ccr_ff[`CBP_CCR_OFF_HI]);

   // done pulses guard against retaking a request still held high
   assign take_dat = dat_req_in & ~dat_done_out;
   assign take_ins = ins_req_in & ~ins_done_out & ~take_dat;
   assign pb_hit   = pb_valid & (pb_addr == ins_addr_in);

   // no lookup for the I/O page
   assign tag_hit   = m_valid & (m_tag == op_addr_ff[AW-1:IDX_W+1]) & ~op_io_ff;
   // descriptor bypass keeps the cache out
   assign cacheable = cache_on & ~op_byp_ff & ~op_io_ff;

   // lookup index: chosen request while idle, else the op in flight
   always @* begin
      rd_idx = op_addr_ff[IDX_W:1];
      if (st_ff == `CBP_ST_IDLE) begin
         if (take_dat) begin
            rd_idx = dat_addr_in[IDX_W:1];
         end else if (take_ins) begin
            rd_idx = ins_addr_in[IDX_W:1];
         end else begin
            rd_idx = pf_addr_ff[IDX_W:1];
         end
      end
   end

   // cache and buffer write controls
   always @* begin
      mw_en    = 1'b0;
      mw_valid = 1'b0;
      mw_data  = op_wdata_ff;
      pb_load  = 1'b0;
      pb_ldata = m_data;
      pb_take  = 1'b0;
      if (st_ff == `CBP_ST_IDLE && take_ins && pb_hit) begin
         pb_take = 1'b1;
      end
      if (st_ff == `CBP_ST_LOOK && !op_we_ff && cacheable && tag_hit) begin
         pb_load = (op_kind_ff == `CBP_OP_FETCH) & ~pf_drop_ff & ~flush;
      end
      if (st_ff == `CBP_ST_BUS && bus_ack_in) begin
         if (!op_we_ff) begin
            mw_data = bus_rdata_in;
         end
         if (op_cach_ff && (!op_we_ff || op_hit_ff)) begin
            // fill on read, write-through update on hit
            mw_en    = 1'b1;
            mw_valid = 1'b1;
         end else if (op_hit_ff) begin
            mw_en    = 1'b1;
            mw_valid = 1'b0;
         end
         pb_load  = (op_kind_ff == `CBP_OP_FETCH) & ~pf_drop_ff & ~flush;
         pb_ldata = bus_rdata_in;
      end
   end

   // cache control register and status
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ccr_ff        <= `CBP_CCR_RESET;
         ccr_rdata_out <= `CBP_CCR_RESET;
         cache_on_out  <= 1'b1;
      end else begin
         if (ccr_wr_in) begin
            ccr_ff        <= ccr_wdata_in;
            ccr_rdata_out <= ccr_wdata_in;
         end
         cache_on_out <= cache_on;
      end
   end

   // indicator held inactive, never driven low
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bus_map_ind_n_out <= 1'b1;
      end else begin
         bus_map_ind_n_out <= 1'b1;
      end
   end

   // main sequencer
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_ff         <= `CBP_ST_IDLE;
         op_kind_ff    <= `CBP_OP_DATA;
         op_addr_ff    <= {AW{1'b0}};
         op_we_ff      <= 1'b0;
         op_wdata_ff   <= {DW{1'b0}};
         op_io_ff      <= 1'b0;
         op_byp_ff     <= 1'b0;
         op_hit_ff     <= 1'b0;
         op_cach_ff    <= 1'b0;
         pf_want_ff    <= 1'b0;
         pf_addr_ff    <= {AW{1'b0}};
         pf_drop_ff    <= 1'b0;
         dat_done_out  <= 1'b0;
         dat_rdata_out <= {DW{1'b0}};
         ins_done_out  <= 1'b0;
         ins_data_out  <= {DW{1'b0}};
         ins_flow_out  <= 1'b0;
         bus_req_out   <= 1'b0;
         bus_we_out    <= 1'b0;
         bus_addr_out  <= {AW{1'b0}};
         bus_wdata_out <= {DW{1'b0}};
      end else begin
         dat_done_out <= 1'b0;
         ins_done_out <= 1'b0;
         // a flush cancels queued and in-flight prefetch
         if (flush) begin
            pf_want_ff <= 1'b0;
            if (st_ff != `CBP_ST_IDLE) begin
               pf_drop_ff <= 1'b1;
            end
         end
         case (st_ff)
            `CBP_ST_IDLE: begin
               pf_drop_ff <= 1'b0;
               if (take_dat) begin
                  op_kind_ff  <= `CBP_OP_DATA;
                  op_addr_ff  <= dat_addr_in;
                  op_we_ff    <= dat_we_in;
                  op_wdata_ff <= dat_wdata_in;
                  // I/O page: top of the physical space
                  op_io_ff    <= &dat_addr_in[AW-1:`CBP_IOPAGE_LSB];
                  op_byp_ff   <= dat_desc_in[`CBP_DESC_BYP_BIT];
                  st_ff       <= `CBP_ST_LOOK;
               end else if (take_ins && pb_hit) begin
                  // hand over buffered word, queue the next one
                  ins_done_out <= 1'b1;
                  ins_data_out <= pb_data;
                  ins_flow_out <= pb_flow;
                  pf_want_ff   <= ~flush;
                  pf_addr_ff   <= ins_addr_in + `CBP_WORD_STEP;
               end else if (take_ins || (pf_want_ff && !flush)) begin
                  // demand fetch on a buffer miss, else the queued prefetch
                  op_kind_ff  <= `CBP_OP_FETCH;
                  op_addr_ff  <= take_ins ? ins_addr_in : pf_addr_ff;
                  op_we_ff    <= 1'b0;
                  op_io_ff    <= take_ins ? &ins_addr_in[AW-1:`CBP_IOPAGE_LSB]
                                          : &pf_addr_ff[AW-1:`CBP_IOPAGE_LSB];
                  op_byp_ff   <= ins_desc_in[`CBP_DESC_BYP_BIT];
                  pf_want_ff  <= 1'b0;
                  st_ff       <= `CBP_ST_LOOK;
               end
            end
            `CBP_ST_LOOK: begin
               op_hit_ff  <= tag_hit;
               op_cach_ff <= cacheable;
               if (!op_we_ff && cacheable && tag_hit) begin
                  // hit served without any check of outside writes
                  st_ff <= `CBP_ST_IDLE;
                  if (op_kind_ff == `CBP_OP_DATA) begin
                     dat_done_out  <= 1'b1;
                     dat_rdata_out <= m_data;
                  end
               end else begin
                  // miss, write or bypass goes out on the bus
                  bus_req_out   <= 1'b1;
                  bus_we_out    <= op_we_ff;
                  bus_addr_out  <= op_addr_ff;
                  bus_wdata_out <= op_wdata_ff;
                  st_ff         <= `CBP_ST_BUS;
               end
            end
            `CBP_ST_BUS: begin
               if (bus_ack_in) begin
                  bus_req_out <= 1'b0;
                  bus_we_out  <= 1'b0;
                  st_ff       <= `CBP_ST_IDLE;
                  if (op_kind_ff == `CBP_OP_DATA) begin
                     dat_done_out  <= 1'b1;
                     dat_rdata_out <= op_we_ff ? op_wdata_ff : bus_rdata_in;
                  end
               end
            end
            default: begin
               st_ff <= `CBP_ST_IDLE;
            end
         endcase
      end
   end

   // cache store
   cbp_cache_mem #(
      .IDX_W (IDX_W),
      .TAG_W (TAG_W),
      .DAT_W (DW)
   ) u_mem (
      .clk_in       (clk_in),
      .rst_n_in     (rst_n_in),
      .rd_idx_in    (rd_idx),
      .rd_valid_out (m_valid),
      .rd_tag_out   (m_tag),
      .rd_data_out  (m_data),
      .wr_en_in     (mw_en),
      .wr_idx_in    (op_addr_ff[IDX_W:1]),
      .wr_valid_in  (mw_valid),
      .wr_tag_in    (op_addr_ff[AW-1:IDX_W+1]),
      .wr_data_in   (mw_data)
   );

   // prefetch buffer
   cbp_prefetch #(
      .AW (AW),
      .DW (DW)
   ) u_pf (
      .clk_in       (clk_in),
      .rst_n_in     (rst_n_in),
      .flush_in     (flush),
      .load_in      (pb_load),
      .load_addr_in (op_addr_ff),
      .load_data_in (pb_ldata),
      .take_in      (pb_take),
      .valid_out    (pb_valid),
      .addr_out     (pb_addr),
      .data_out     (pb_data),
      .predec_out   (pb_flow)
   );
endmodule

//--- rtl/cbp_defines.vh
// Purpose: shared constants for the cache bypass and prefetch control block
// Assumes: 22-bit physical byte addresses, 16-bit data, one clock
// Notes:   included by cbp_top only; the other design files of the block take parameters
// How it works
// - A reference whose address lies in the I/O page goes to the bus and never looks up or fills the cache.
// - A reference whose page descriptor has bit 15 set goes to main memory instead of being served from the cache.
// - A bypassed reference that matches a valid entry invalidates that entry instead of using or updating it.
// - Writes by other bus masters are not watched, so a later hit may return a stale cached word.
// - Writing the disable bits of the cache control register turns the cache off or on for later references.
// - After each instruction is handed over, the next sequential word is fetched and predecoded ahead of use.
// - A write to the status word, the cache control register, the program counter or a mapping register flushes
//      all prefetched instructions.
// - Writes to control registers of outside devices leave prefetched instructions in place.
// - A taken branch changes the program counter and so flushes the prefetch pipeline.
// - The bus map indicator is never asserted on the backplane.
// - After reset the cache is enabled with no software action and works unseen by programs.
// - While the cache is enabled every word read from main memory without descriptor bypass is written into the cache.
`ifndef CBP_DEFINES_VH
`define CBP_DEFINES_VH

`define CBP_AW            22
`define CBP_DW            16
`define CBP_IDX_W         11
`define CBP_IOPAGE_LSB    13
`define CBP_DESC_BYP_BIT  15
`define CBP_CCR_OFF_LO    2
`define CBP_CCR_OFF_HI    3
`define CBP_CCR_RESET     16'h0000
`define CBP_ST_IDLE       2'h0
`define CBP_ST_LOOK       2'h1
`define CBP_ST_BUS        2'h2
`define CBP_OP_DATA       1'b0
`define CBP_OP_FETCH      1'b1
`define CBP_WORD_STEP     22'h000002

`endif

//--- rtl/cbp_cache_mem.v
// Purpose: direct-mapped cache store with valid bits, registered read
// Assumes: one read and one write port, same clock
// Notes:   only the valid bits and the read-port registers are reset; stored data and tags power up unknown
`timescale 1ns/1ps
module cbp_cache_mem #(
   parameter IDX_W = 11,
   parameter TAG_W = 10,
   parameter DAT_W = 16
) (
   input  wire             clk_in,       // clock
   input  wire             rst_n_in,     // async reset, low
   input  wire [IDX_W-1:0] rd_idx_in,    // read index
   output reg              rd_valid_out, // entry valid
   output reg  [TAG_W-1:0] rd_tag_out,   // entry tag
   output reg  [DAT_W-1:0] rd_data_out,  // entry data
   input  wire             wr_en_in,     // write strobe
   input  wire [IDX_W-1:0] wr_idx_in,    // write index
   input  wire             wr_valid_in,  // new valid bit
   input  wire [TAG_W-1:0] wr_tag_in,    // new tag
   input  wire [DAT_W-1:0] wr_data_in    // new data
);
   localparam DEPTH = 1 << IDX_W;

   reg [TAG_W-1:0] tag_mem [0:DEPTH-1];
   reg [DAT_W-1:0] dat_mem [0:DEPTH-1];
   reg [DEPTH-1:0] valid_ff;

   // valid bits cleared at reset so no never-written entry is ever returned as a hit
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         valid_ff <= {DEPTH{1'b0}};
      end else if (wr_en_in) begin
         valid_ff[wr_idx_in] <= wr_valid_in;
      end
   end

   // arrays, no reset
   always @(posedge clk_in) begin
      if (wr_en_in) begin
         tag_mem[wr_idx_in] <= wr_tag_in;
         dat_mem[wr_idx_in] <= wr_data_in;
      end
   end

   // registered read port
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_valid_out <= 1'b0;
         rd_tag_out   <= {TAG_W{1'b0}};
         rd_data_out  <= {DAT_W{1'b0}};
      end else begin
         rd_valid_out <= valid_ff[rd_idx_in];
         rd_tag_out   <= tag_mem[rd_idx_in];
         rd_data_out  <= dat_mem[rd_idx_in];
      end
   end
endmodule

//--- rtl/cbp_prefetch.v
// Purpose: one-word prefetch buffer with predecode
// Assumes: loads and takes come from the controller on the same clock
// Notes:   flush wins over a load in the same cycle
`timescale 1ns/1ps
module cbp_prefetch #(
   parameter AW = 22,
   parameter DW = 16
) (
   input  wire          clk_in,        // clock
   input  wire          rst_n_in,      // async reset, low
   input  wire          flush_in,      // discard buffer
   input  wire          load_in,       // store fetched word
   input  wire [AW-1:0] load_addr_in,  // its address
   input  wire [DW-1:0] load_data_in,  // its data
   input  wire          take_in,       // word handed to core
   output reg           valid_out,     // buffer holds a word
   output reg  [AW-1:0] addr_out,      // buffered address
   output reg  [DW-1:0] data_out,      // buffered word
   output reg           predec_out     // word alters flow
);
   reg pre_flow;

   // predecode: branch group or jump/return class alters sequential flow
   always @* begin
      pre_flow = 1'b0;
      if (load_data_in[14:11] == 4'h0 && load_data_in[10:8] != 3'h0) begin
         pre_flow = 1'b1;
      end
      if (load_data_in[15:6] == 10'h001 || load_data_in[15:3] == 13'h0010) begin
         pre_flow = 1'b1;
      end
   end

   // buffer state
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         valid_out  <= 1'b0;
         addr_out   <= {AW{1'b0}};
         data_out   <= {DW{1'b0}};
         predec_out <= 1'b0;
      end else if (flush_in) begin
         valid_out <= 1'b0;
      end else if (load_in) begin
         valid_out  <= 1'b1;
         addr_out   <= load_addr_in;
         data_out   <= load_data_in;
         predec_out <= pre_flow;
      end else if (take_in) begin
         valid_out <= 1'b0;
      end
   end
endmodule

//--- dv/cbp_asserts.sv
// Purpose: port-level checks of the cache bypass and prefetch block
// Assumes: bound into cbp_top, one clock domain
// Notes:   bus slave is synchronous, so done follows ack by one cycle
`timescale 1ns/1ps
module cbp_asserts #(
   parameter AW    = 22,
   parameter DW    = 16,
   parameter IDX_W = 11
) (
   input wire          clk_in,            // clock
   input wire          rst_n_in,          // reset, low
   input wire          dat_req_in,        // data request
   input wire [AW-1:0] dat_addr_in,       // data address
   input wire [DW-1:0] dat_desc_in,       // descriptor
   input wire          dat_done_out,      // data done
   input wire          ins_done_out,      // fetch done
   input wire          ccr_wr_in,         // control write
   input wire [DW-1:0] ccr_wdata_in,      // control data
   input wire [DW-1:0] ccr_rdata_out,     // control readback
   input wire          cache_on_out,      // cache enabled
   input wire          bus_req_out,       // bus request
   input wire          bus_we_out,        // bus write
   input wire [AW-1:0] bus_addr_out,      // bus address
   input wire          bus_ack_in,        // bus ack
   input wire          bus_map_ind_n_out  // map indicator
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   a_map_ind_idle: assert property (bus_map_ind_n_out)
      else $error("map indicator asserted");
   a_ccr_load_data: assert property (ccr_wr_in |=> ccr_rdata_out == $past(ccr_wdata_in))
      else $error("ccr not loaded");
   a_cache_on_follow: assert property (cache_on_out == ($past(ccr_rdata_out[3:2]) == 2'h0))
      else $error("enable not following ccr");
   // bus cycle held until ack
   a_bus_req_hold: assert property (bus_req_out && !bus_ack_in |=>
      bus_req_out && $stable(bus_addr_out) && $stable(bus_we_out))
      else $error("bus changed before ack");
   a_bus_req_drop: assert property (bus_req_out && bus_ack_in |=> !bus_req_out)
      else $error("req held after ack");
   a_io_to_bus: assert property (dat_done_out && dat_req_in && (&dat_addr_in[AW-1:13]) |-> $past(bus_ack_in))
      else $error("io ref not on bus");
   a_bypass_to_bus: assert property (dat_done_out && dat_req_in && dat_desc_in[15] |-> $past(bus_ack_in))
      else $error("bypass ref from cache");
   a_off_to_bus: assert property (dat_done_out && !cache_on_out && !$past(cache_on_out) &&
      !$past(cache_on_out, 2) |-> $past(bus_ack_in))
      else $error("cache off but hit");
   a_dat_done_pulse: assert property (dat_done_out |=> !dat_done_out)
      else $error("data done too long");
   a_ins_done_pulse: assert property (ins_done_out |=> !ins_done_out)
      else $error("fetch done too long");
endmodule

bind cbp_top cbp_asserts #(.AW(AW), .DW(DW), .IDX_W(IDX_W)) u_cbp_asserts (.*);

//--- dv/cbp_bus_model.sv
// Purpose: synchronous backplane slave for memory and devices
// Assumes: one cycle at a time, ack is a one-cycle pulse
// Notes:   poke stands in for another master writing behind the cache
`timescale 1ns/1ps
module cbp_bus_model (
   input  wire        clk_in,        // clock
   input  wire        rst_n_in,      // reset, low
   input  wire        slow_in,       // add wait states
   input  wire        bus_req_in,    // cycle request
   input  wire        bus_we_in,     // write
   input  wire [21:0] bus_addr_in,   // address
   input  wire [15:0] bus_wdata_in,  // write data
   output reg         bus_ack_out,   // ack pulse
   output reg  [15:0] bus_rdata_out  // read data
);
   logic [15:0] mem [int];
   int          wait_ff;

   // unwritten words show a pattern tied to the address
   function automatic logic [15:0] peek(input logic [21:0] a);
      return mem.exists(a[21:1]) ? mem[a[21:1]] : (a[16:1] ^ 16'h5A5A);
   endfunction

   task automatic poke(input logic [21:0] a, input logic [15:0] d);
      mem[a[21:1]] = d;
   endtask

   // data line toggles outside ack so a late sample never looks right
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bus_ack_out   <= 1'b0;
         bus_rdata_out <= 16'h0000;
         wait_ff       <= 0;
      end else if (bus_ack_out || !bus_req_in) begin
         bus_ack_out   <= 1'b0;
         bus_rdata_out <= ~bus_rdata_out;
         wait_ff       <= 0;
      end else if (wait_ff < (slow_in ? 5 : 1)) begin
         wait_ff       <= wait_ff + 1;
         bus_rdata_out <= ~bus_rdata_out;
      end else begin
         bus_ack_out   <= 1'b1;
         bus_rdata_out <= peek(bus_addr_in);
         if (bus_we_in)
            mem[bus_addr_in[21:1]] = bus_wdata_in;
      end
   end
endmodule

//--- dv/tb_top.sv
// Purpose: self-checking bench for cbp_top
// Assumes: synchronous bus slave model on the far side
// Notes:   expected words follow the slave fill pattern
`timescale 1ns/1ps
module tb_top;
   localparam logic [21:0] A = 22'h000100, B = 22'h000200, IO = 22'h3FE010, P = 22'h001000, Q = 22'h002000;
   logic        clk_in = 1'b0, rst_n_in = 1'b0, slow_in = 1'b0;
   logic        dat_req_in = 1'b0, dat_we_in = 1'b0, ins_req_in = 1'b0, ccr_wr_in = 1'b0;
   logic        psw_wr_in = 1'b0, pc_wr_in = 1'b0, mmu_wr_in = 1'b0, branch_taken_in = 1'b0;
   logic [21:0] dat_addr_in = 22'h000000, ins_addr_in = 22'h000000, bus_addr_out;
   logic [15:0] dat_wdata_in = 16'h0000, dat_desc_in = 16'h0000, ins_desc_in = 16'h0000, ccr_wdata_in = 16'h0000;
   logic [15:0] dat_rdata_out, ins_data_out, ccr_rdata_out, bus_wdata_out, bus_rdata_in, rd, d;
   logic        dat_done_out, ins_done_out, ins_flow_out, cache_on_out, bus_req_out, bus_we_out;
   logic        bus_ack_in, bus_map_ind_n_out, f;
   int          failures = 0, total_checks = 0, nbus = 0, cyc, n0;

   cbp_top #(.AW(22), .DW(16), .IDX_W(11)) u_cbp_top (.*);
   cbp_bus_model u_cbp_bus_model (.clk_in, .rst_n_in, .slow_in, .bus_req_in(bus_req_out),
      .bus_we_in(bus_we_out), .bus_addr_in(bus_addr_out), .bus_wdata_in(bus_wdata_out),
      .bus_ack_out(bus_ack_in), .bus_rdata_out(bus_rdata_in));

   always #50 clk_in = ~clk_in;
   // completed bus cycles, to tell cache hits from misses
   always @(posedge clk_in) if (bus_req_out && bus_ack_in) nbus <= nbus + 1;

   function automatic logic [15:0] dflt(input logic [21:0] a);
      return a[16:1] ^ 16'h5A5A;
   endfunction
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // request held until the done pulse is sampled
   task automatic dat(input logic we, input logic [21:0] a, input logic [15:0] wd, input logic [15:0] desc,
                      output logic [15:0] rd, output int cyc);
      @(posedge clk_in);
      dat_req_in   <= 1'b1;
      dat_we_in    <= we;
      dat_addr_in  <= a;
      dat_wdata_in <= wd;
      dat_desc_in  <= desc;
      cyc = 0;
      do begin
         @(posedge clk_in);
         cyc++;
      end while (dat_done_out !== 1'b1 && cyc < 200);
      rd = dat_rdata_out;
      dat_req_in <= 1'b0;
   endtask
   task automatic ins(input logic [21:0] a, output logic [15:0] d, output logic f, output int cyc);
      @(posedge clk_in);
      ins_req_in  <= 1'b1;
      ins_addr_in <= a;
      cyc = 0;
      do begin
         @(posedge clk_in);
         cyc++;
      end while (ins_done_out !== 1'b1 && cyc < 200);
      d = ins_data_out;
      f = ins_flow_out;
      ins_req_in <= 1'b0;
   endtask
   // one-cycle write strobe: 0 status, 1 counter, 2 mapping, 3 branch, 4 control
   task automatic pulse(input int k, input logic [15:0] v);
      @(posedge clk_in);
      {psw_wr_in, pc_wr_in, mmu_wr_in, branch_taken_in, ccr_wr_in} <= 5'h10 >> k;
      ccr_wdata_in <= v;
      @(posedge clk_in);
      {psw_wr_in, pc_wr_in, mmu_wr_in, branch_taken_in, ccr_wr_in} <= 5'h00;
   endtask

   task automatic t_reset;
      chk("cache_on", cache_on_out, 1);
      chk("ccr", ccr_rdata_out, 0);
      chk("map_ind_n", bus_map_ind_n_out, 1);
      $display("test reset done");
   endtask
   task automatic t_cache;
      n0 = nbus;
      dat(0, A, 0, 0, rd, cyc);
      chk("miss data", rd, dflt(A));
      dat(0, A, 0, 0, rd, cyc);
      chk("hit cycles", cyc, 3);
      chk("hit bus", nbus - n0, 1);
      u_cbp_bus_model.poke(A, 16'hBEEF);
      dat(0, A, 0, 0, rd, cyc);
      chk("stale hit", rd, dflt(A));
      $display("test cache done");
   endtask
   task automatic t_bypass;
      n0 = nbus;
      dat(0, A, 0, 16'h8000, rd, cyc);
      chk("bypass data", rd, 16'hBEEF);
      dat(0, A, 0, 0, rd, cyc);
      chk("refill data", rd, 16'hBEEF);
      dat(1, A, 16'h1357, 16'h8000, rd, cyc);
      dat(0, A, 0, 0, rd, cyc);
      chk("after write", rd, 16'h1357);
      chk("bypass bus", nbus - n0, 4);
      $display("test bypass done");
   endtask
   task automatic t_io;
      slow_in <= 1'b1;
      n0 = nbus;
      dat(0, IO, 0, 0, rd, cyc);
      chk("io data", rd, dflt(IO));
      dat(1, IO, 16'h00AA, 0, rd, cyc);
      dat(0, IO, 0, 0, rd, cyc);
      chk("io reread", rd, 16'h00AA);
      chk("io bus", nbus - n0, 3);
      slow_in <= 1'b0;
      $display("test io done");
   endtask
   task automatic t_ccr;
      for (int b = 2; b <= 3; b++) begin
         pulse(4, 16'h0001 << b);
         repeat (2) @(posedge clk_in);
         chk("ccr read", ccr_rdata_out, 32'h1 << b);
         chk("cache off", cache_on_out, 0);
         u_cbp_bus_model.poke(A, 16'h2468);
         n0 = nbus;
         dat(0, A, 0, 0, rd, cyc);
         chk("off data", rd, 16'h2468);
         dat(0, B, 0, 0, rd, cyc);
         dat(0, B, 0, 0, rd, cyc);
         chk("off bus", nbus - n0, 3);
      end
      pulse(4, 16'h0000);
      repeat (2) @(posedge clk_in);
      chk("cache back on", cache_on_out, 1);
      n0 = nbus;
      dat(0, B, 0, 0, rd, cyc);
      dat(0, B, 0, 0, rd, cyc);
      chk("on hit cycles", cyc, 3);
      chk("on bus", nbus - n0, 1);
      $display("test control done");
   endtask
   task automatic t_pref;
      logic [21:0] x;
      u_cbp_bus_model.poke(P, 16'h1234);
      u_cbp_bus_model.poke(P + 22'h2, 16'h0100);
      ins(P, d, f, cyc);
      chk("ins data", d, 16'h1234);
      chk("ins flow", f, 0);
      repeat (20) @(posedge clk_in);
      ins(P + 22'h2, d, f, cyc);
      chk("pref cycles", cyc, 2);
      chk("pref data", d, 16'h0100);
      chk("pref flow", f, 1);
      x = P + 22'h4;
      for (int k = 0; k < 5; k++) begin
         repeat (20) @(posedge clk_in);
         pulse(k, 16'h0000);
         ins(x, d, f, cyc);
         chk("flush refetch", cyc > 3, 1);
         chk("flush data", d, dflt(x));
         x = x + 22'h2;
      end
      $display("test prefetch done");
   endtask
   task automatic t_remap;
      ins(Q, d, f, cyc);
      repeat (20) @(posedge clk_in);
      u_cbp_bus_model.poke(Q + 22'h2, 16'hCAFE);
      dat(1, IO, 16'h0001, 0, rd, cyc);
      ins(Q + 22'h2, d, f, cyc);
      chk("remap cycles", cyc, 2);
      chk("remap data", d, dflt(Q + 22'h2));
      $display("test remap done");
   endtask

   initial begin
      repeat (10) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      t_reset();
      t_cache();
      t_bypass();
      t_io();
      t_ccr();
      t_pref();
      t_remap();
      final_report();
   end
   // the tests need well under 2000 cycles; allow 10000
   initial begin
      #1000000;
      failures++;
      final_report();
   end
endmodule
